//--- sei_pkg.sv
package sei_pkg;

   // Register byte offsets on the Wishbone slave
   localparam logic [7:0] OFS_LINE1 = 8'h00;
   localparam logic [7:0] OFS_LINE2 = 8'h04;
   localparam logic [7:0] OFS_LINE3 = 8'h08;
   localparam logic [7:0] OFS_L2X   = 8'h0C;
   localparam logic [7:0] OFS_L3X   = 8'h10;
   localparam logic [7:0] OFS_CTRL  = 8'h14;
   localparam logic [7:0] OFS_STAT  = 8'h18;

   // Setup word fields, then result widths and arctangent step count
   localparam int         LINE_W     = 24;
   localparam int         VARIANT_B  = 19;
   localparam logic [3:0] METHOD_F   = 4'hF;
   localparam logic [3:0] DIGIT_ZERO = 4'h0;
   localparam logic [7:0] BYTE_ZERO  = 8'h00;
   localparam int         FRAC_W     = 12;
   localparam int         ANG_W      = 16;
   localparam int         CORDIC_N   = 14;

   // Counter word offset from channel base, per servo IC generation; cosine word offset from the sine word
   localparam logic [15:0] CNT_OFS_GEN1 = 16'h0001;
   localparam logic [15:0] CNT_OFS_GEN2 = 16'h0000;
   localparam logic [15:0] COS_OFS      = 16'h0001;

   // Control and status bits
   localparam int CTL_EN    = 0;
   localparam int CTL_THREE = 1;
   localparam int ST_ERR    = 0;
   localparam int ST_OVR    = 1;
   localparam int ST_DIR    = 2;
   localparam int ST_BUSY   = 3;
   localparam int ST_DIAG   = 4;

   localparam logic [23:0] RST_LINE = 24'h000000;
   localparam logic [1:0]  RST_CTRL = 2'h0;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_CNT  = 3'h1,
      S_SIN  = 3'h3,
      S_COS  = 3'h2,
      S_ATAN = 3'h6,
      S_DONE = 3'h7
   } sei_state_type;

   typedef struct packed {
      logic        req;
      logic [15:0] addr;
   } sei_fetch_req_type;

endpackage : sei_pkg

//--- sei_atan.sv
`timescale 1ns/1ns
module sei_atan
(
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // Operands
   input  wire logic                start_i,
   input  wire logic signed [12:0]  sin_i,
   input  wire logic signed [12:0]  cos_i,
   // Result
   output logic                     done_o,
   output logic [sei_pkg::FRAC_W-1:0] angle_o
);

   typedef struct packed {
      logic        busy;
      logic        done;
      logic [3:0]  idx;
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
   } sei_atan_type;

   sei_atan_type r;
   sei_atan_type n;

   // Angle of atan(2^-i) in 1/65536 of a turn
   function automatic logic [15:0] atan_tab(input logic [3:0] i);
      case (i)
         4'h0:    atan_tab = 16'h2000;
         4'h1:    atan_tab = 16'h12E4;
         4'h2:    atan_tab = 16'h09FB;
         4'h3:    atan_tab = 16'h0511;
         4'h4:    atan_tab = 16'h028B;
         4'h5:    atan_tab = 16'h0146;
         4'h6:    atan_tab = 16'h00A3;
         4'h7:    atan_tab = 16'h0051;
         4'h8:    atan_tab = 16'h0029;
         4'h9:    atan_tab = 16'h0014;
         4'hA:    atan_tab = 16'h000A;
         4'hB:    atan_tab = 16'h0005;
         4'hC:    atan_tab = 16'h0003;
         4'hD:    atan_tab = 16'h0001;
         default: atan_tab = 16'h0000;
      endcase
   endfunction : atan_tab

   always_comb
   begin
      logic [15:0] xs;
      logic [15:0] ys;
      logic [15:0] xe;
      logic [15:0] ye;
      xs = 16'h0000;
      ys = 16'h0000;
      xe = {{3{cos_i[12]}}, cos_i};
      ye = {{3{sin_i[12]}}, sin_i};
      n = r;
      n.done = 1'b0;
      if (start_i)
      begin
         // Fold the left half-plane over so the iteration converges
         n.busy = 1'b1;
         n.idx  = 4'h0;
         if (cos_i[12])
         begin
            n.x = 16'h0000 - xe;
            n.y = 16'h0000 - ye;
            n.z = 16'h8000;
         end
         else
         begin
            n.x = xe;
            n.y = ye;
            n.z = 16'h0000;
         end
      end
      else if (r.busy)
      begin
         xs = 16'($signed(r.x) >>> r.idx);
         ys = 16'($signed(r.y) >>> r.idx);
         if (!r.y[15])
         begin
            n.x = r.x + ys;
            n.y = r.y - xs;
            n.z = r.z + atan_tab(r.idx);
         end
         else
         begin
            n.x = r.x - ys;
            n.y = r.y + xs;
            n.z = r.z - atan_tab(r.idx);
         end
         n.idx = r.idx + 4'h1;
         if (r.idx == 4'(sei_pkg::CORDIC_N - 1))
         begin
            n.busy = 1'b0;
            n.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         r <= '0;
      else
         r <= n;
   end

   assign done_o  = r.done;
   assign angle_o = r.z[sei_pkg::ANG_W-1:sei_pkg::ANG_W-sei_pkg::FRAC_W];

endmodule : sei_atan

//--- sei_interp.sv
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
module sei_interp
(
   // Clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   // Wishbone slave
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [7:0]                  wb_adr_i,
   input  wire logic [3:0]                  wb_sel_i,
   input  wire logic [31:0]                 wb_dat_i,
   output logic [31:0]                      wb_dat_o,
   output logic                             wb_ack_o,
   // Servo cycle and counter direction
   input  wire logic                        servo_tick_i,
   input  wire logic                        counter_dir_i,
   // Fetch port toward counter and A/D words
   output sei_pkg::sei_fetch_req_type       fetch_o,
   input  wire logic [23:0]                 fetch_data_i,
   input  wire logic                        fetch_ack_i,
   // Result
   output logic [23:0]                      pos_o,
   output logic                             pos_valid_o
);

   typedef struct packed {
      sei_pkg::sei_state_type st;
      logic        ack;
      logic [31:0] dat;
      logic [23:0] line1;
      logic [23:0] line2;
      logic [23:0] line3;
      logic [23:0] l2x;
      logic [23:0] l3x;
      logic [1:0]  ctl;
      logic        err;
      logic        ovr;
      logic        diag;
      logic        dir_taken;
      logic        dir_rev;
      logic [23:0] cnt;
      logic [23:0] sin;
      logic [23:0] cos;
      logic        req;
      logic [15:0] addr;
      logic        go;
      logic [23:0] pos;
      logic        upd;
   } sei_regs_type;

   sei_regs_type r;
   sei_regs_type n;

   logic                       atan_done;
   logic [sei_pkg::FRAC_W-1:0] atan_angle;
   logic signed [12:0]         sin_b;
   logic signed [12:0]         cos_b;

   // Word decode; byte address bits 1:0 are ignored
   function automatic logic hit(input logic [7:0] adr,
                                input logic [7:0] ofs);
      hit = (adr[7:2] == ofs[7:2]);
   endfunction : hit

   // Whole lines sit above the fraction: 4096 fraction states per line
   function automatic logic [23:0] pos_word(input logic [23:0] cnt,
                                            input logic [11:0] frac);
      pos_word = {cnt[11:0], frac};
   endfunction : pos_word

   // Byte-lane merge of a 24-bit word; lane 3 has no storage
   function automatic logic [23:0] merge(input logic [23:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  sel);
      logic [23:0] m;
      m = old;
      for (int b = 0; b < 3; b++)
      begin
         if (sel[b])
            m[b*8 +: 8] = wd[b*8 +: 8];
      end
      merge = m;
   endfunction : merge

   // Bias is added to the top 12 bits, widened to keep the carry
   assign sin_b = $signed({r.sin[23], r.sin[23:12]})
                + $signed({r.line3[23], r.line3[23:12]});
   assign cos_b = $signed({r.cos[23], r.cos[23:12]})
                + $signed({r.line3[11], r.line3[11:0]});

   sei_atan u_atan
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (r.go),
      .sin_i   (sin_b),
      .cos_i   (cos_b),
      .done_o  (atan_done),
      .angle_o (atan_angle)
   );

   always_comb
   begin
      logic        three;
      logic        setup_ok;
      logic        wr;
      logic [15:0] cnt_ofs;
      logic [11:0] frac;
      logic        take;
      three    = r.ctl[sei_pkg::CTL_THREE];
      take     = wb_cyc_i && wb_stb_i && !r.ack;
      setup_ok = 1'b0;
      wr       = 1'b0;
      cnt_ofs  = sei_pkg::CNT_OFS_GEN2;
      frac     = 12'h000;
      n        = r;
      n.upd    = 1'b0;
      n.go     = 1'b0;

      // Wishbone: one wait state, ack for exactly one cycle
      n.ack = take;
      wr    = take && wb_we_i;
      n.dat = 32'h00000000;
      if (take && !wb_we_i)
      begin
         if (hit(wb_adr_i, sei_pkg::OFS_LINE1))
            n.dat = {8'h00, r.line1};
         else if (hit(wb_adr_i, sei_pkg::OFS_LINE2))
            n.dat = {8'h00, r.line2};
         else if (hit(wb_adr_i, sei_pkg::OFS_LINE3))
            n.dat = {8'h00, r.line3};
         else if (hit(wb_adr_i, sei_pkg::OFS_L2X))
            n.dat = {8'h00, r.l2x};
         else if (hit(wb_adr_i, sei_pkg::OFS_L3X))
            n.dat = {8'h00, r.l3x};
         else if (hit(wb_adr_i, sei_pkg::OFS_CTRL))
            n.dat = {30'h00000000, r.ctl};
         // Busy is read live from the state, not stored
         else if (hit(wb_adr_i, sei_pkg::OFS_STAT))
            n.dat = {27'h0000000, r.diag, (r.st != sei_pkg::S_IDLE),
                     r.dir_rev, r.ovr, r.err};
      end
      if (wr)
      begin
         if (hit(wb_adr_i, sei_pkg::OFS_LINE1))
            n.line1 = merge(r.line1, wb_dat_i, wb_sel_i);
         if (hit(wb_adr_i, sei_pkg::OFS_LINE2))
            n.line2 = merge(r.line2, wb_dat_i, wb_sel_i);
         if (hit(wb_adr_i, sei_pkg::OFS_LINE3))
            n.line3 = merge(r.line3, wb_dat_i, wb_sel_i);
         if (hit(wb_adr_i, sei_pkg::OFS_CTRL) && wb_sel_i[0])
            n.ctl = wb_dat_i[1:0];
         if (hit(wb_adr_i, sei_pkg::OFS_STAT) && wb_sel_i[0])
         begin
            if (wb_dat_i[sei_pkg::ST_ERR])
               n.err = 1'b0;
            if (wb_dat_i[sei_pkg::ST_OVR])
               n.ovr = 1'b0;
            if (wb_dat_i[sei_pkg::ST_DIAG])
               n.diag = 1'b0;
         end
      end

      // Sense is taken once; a later change needs a reset to apply
      if (!r.dir_taken)
      begin
         n.dir_taken = 1'b1;
         n.dir_rev   = counter_dir_i;
      end

      // Setup check; in three-line form bit 19 set means diagnostic form
      if (three)
         setup_ok = (r.line1[23:20] == sei_pkg::METHOD_F)
                 && (r.line1[19:16] == sei_pkg::DIGIT_ZERO);
      else
         setup_ok = (r.line1[23:20] == sei_pkg::METHOD_F)
                 && (r.line1[18:16] == 3'h0);
      // Line 2 upper byte must be clear in both forms
      setup_ok = setup_ok
              && (r.line2[23:16] == sei_pkg::BYTE_ZERO);
      // First-generation layout puts the counter word above the base
      if (!three && !r.line1[sei_pkg::VARIANT_B])
         cnt_ofs = sei_pkg::CNT_OFS_GEN1;

      // Events set status bits after the clear, so a set wins
      case (r.st)
         sei_pkg::S_IDLE:
         begin
            if (servo_tick_i && r.ctl[sei_pkg::CTL_EN] && r.dir_taken)
            begin
               if (setup_ok)
               begin
                  n.st   = sei_pkg::S_CNT;
                  n.req  = 1'b1;
                  n.addr = r.line1[15:0] + cnt_ofs;
               end
               else
               begin
                  n.err = 1'b1;
                  if (three && r.line1[sei_pkg::VARIANT_B])
                     n.diag = 1'b1;
               end
            end
         end
         // Address moves only on an answer, so a slow responder sees it held
         sei_pkg::S_CNT:
         begin
            if (fetch_ack_i)
            begin
               n.cnt  = fetch_data_i;
               n.st   = sei_pkg::S_SIN;
               n.addr = r.line2[15:0];
            end
         end
         sei_pkg::S_SIN:
         begin
            if (fetch_ack_i)
            begin
               n.sin  = fetch_data_i;
               n.st   = sei_pkg::S_COS;
               n.addr = r.line2[15:0] + sei_pkg::COS_OFS;
            end
         end
         sei_pkg::S_COS:
         begin
            if (fetch_ack_i)
            begin
               n.cos = fetch_data_i;
               n.req = 1'b0;
               n.go  = 1'b1;
               n.st  = sei_pkg::S_ATAN;
            end
         end
         // Arctangent works on the registered, biased readings
         sei_pkg::S_ATAN:
         begin
            if (atan_done)
               n.st = sei_pkg::S_DONE;
         end
         sei_pkg::S_DONE:
         begin
            // Reversed sense mirrors the fraction inside the line
            frac = r.dir_rev ? (12'h000 - atan_angle) : atan_angle;
            n.pos = pos_word(r.cnt, frac);
            if (three)
               n.l3x = pos_word(r.cnt, frac);
            else
               n.l2x = pos_word(r.cnt, frac);
            n.upd = 1'b1;
            n.st  = sei_pkg::S_IDLE;
         end
         // An illegal state drops the request so the fetch port is freed
         default:
         begin
            n.st  = sei_pkg::S_IDLE;
            n.req = 1'b0;
         end
      endcase

      // A tick during a fetch is dropped; coherence beats catching up
      if (servo_tick_i && (r.st != sei_pkg::S_IDLE))
         n.ovr = 1'b1;
   end

   // Named reset values are laid over the cleared state
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r       <= '0;
         r.st    <= sei_pkg::S_IDLE;
         r.line1 <= sei_pkg::RST_LINE;
         r.line2 <= sei_pkg::RST_LINE;
         r.line3 <= sei_pkg::RST_LINE;
         r.ctl   <= sei_pkg::RST_CTRL;
      end
      else
         r <= n;
   end

   // Every output leaves a flip-flop; result and strobe move together
   assign wb_ack_o     = r.ack;
   assign wb_dat_o     = r.dat;
   assign fetch_o.req  = r.req;
   assign fetch_o.addr = r.addr;
   assign pos_o        = r.pos;
   assign pos_valid_o  = r.upd;

endmodule : sei_interp

//--- sei_fetch_model.sv
`timescale 1ns/1ns
module sei_fetch_model
(
   // Clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   // Request and expected map
   input  wire sei_pkg::sei_fetch_req_type fetch_i,
   input  wire logic [3:0]                 wait_i,
   input  wire logic [15:0]                cnt_adr_i,
   input  wire logic [15:0]                adc_adr_i,
   input  wire logic [23:0]                cnt_val_i,
   input  wire logic [23:0]                sin_val_i,
   input  wire logic [23:0]                cos_val_i,
   // Answer
   output logic [23:0]                     data_o,
   output logic                            ack_o,
   output logic                            miss_o
);
   logic [3:0]  cnt;
   logic [23:0] pick;
   logic        bad;
   always_comb
   begin
      bad = 1'b0;
      if (fetch_i.addr == cnt_adr_i)
         pick = cnt_val_i;
      else if (fetch_i.addr == adc_adr_i)
         pick = sin_val_i;
      else if (fetch_i.addr == adc_adr_i + 16'h0001)
         pick = cos_val_i;
      else
      begin
         pick = 24'h5A5A5A;
         bad = 1'b1;
      end
   end
   // Data lines toggle when not answering so stale words never pass
   always_ff @(posedge clk_i)
   begin
      ack_o <= 1'b0;
      data_o <= ~data_o;
      if (rst_i)
      begin
         cnt <= 4'h0;
         miss_o <= 1'b0;
         data_o <= 24'h000000;
      end
      else if (fetch_i.req && !ack_o)
      begin
         cnt <= cnt + 4'h1;
         if (cnt >= wait_i)
         begin
            cnt <= 4'h0;
            ack_o <= 1'b1;
            data_o <= pick;
            miss_o <= miss_o | bad;
         end
      end
   end
endmodule : sei_fetch_model

//--- sei_interp_asserts.sv
`timescale 1ns/1ns
module sei_interp_asserts
(
   // Clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   // Wishbone
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic [31:0]                wb_dat_o,
   input  wire logic                       wb_ack_o,
   // Fetch and result
   input  wire sei_pkg::sei_fetch_req_type fetch_o,
   input  wire logic                       fetch_ack_i,
   input  wire logic [23:0]                pos_o,
   input  wire logic                       pos_valid_o
);
   logic [1:0] acks_r;
   logic [1:0] acks_nxt;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   always_comb
   begin
      acks_nxt = acks_r;
      if (!fetch_o.req)
         acks_nxt = 2'h0;
      else if (fetch_ack_i)
         acks_nxt = acks_r + 2'h1;
   end
   always_ff @(posedge clk_i)
      acks_r <= rst_i ? 2'h0 : acks_nxt;
   a_ack_next: assert property
      (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:24] == 8'h00)
      else $error("upper read byte not zero");
   a_req_hold: assert property
      (fetch_o.req && !fetch_ack_i |=> fetch_o.req && $stable(fetch_o.addr))
      else $error("fetch request not held");
   a_cos_next: assert property
      (acks_r == 2'h2 && $past(acks_r) == 2'h1
       |-> fetch_o.addr == $past(fetch_o.addr) + 16'h0001)
      else $error("cosine address not sine plus one");
   a_three_acks: assert property ($fell(fetch_o.req) |-> acks_r == 2'h3)
      else $error("fetch ended without three words");
   a_result_due: assert property
      ($fell(fetch_o.req) |-> ##[1:40] pos_valid_o)
      else $error("no result after fetch");
   a_valid_pulse: assert property (pos_valid_o |=> !pos_valid_o)
      else $error("result strobe too long");
   a_pos_hold: assert property ($changed(pos_o) |-> pos_valid_o)
      else $error("position changed without strobe");
   c_bus: cover property (wb_cyc_i && wb_ack_o);
   c_fetch: cover property ($fell(fetch_o.req));
   c_result: cover property (pos_valid_o);
endmodule : sei_interp_asserts

bind sei_interp sei_interp_asserts chk_u
(
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fetch_o(fetch_o),
   .fetch_ack_i(fetch_ack_i), .pos_o(pos_o), .pos_valid_o(pos_valid_o)
);

//--- sei_interp_tb.sv
`timescale 1ns/1ns
module sei_interp_tb;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic tck = 1'b0, dir = 1'b0, ack, fack, miss, pval, got;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat = 32'h0, rd, dout;
   logic [3:0]  wt = 4'h0;
   logic [15:0] cadr = 16'h0, aadr = 16'h0;
   logic [23:0] cval = 24'h0, sval = 24'h0, cosv = 24'h0, fdat, pos_o, pos;
   logic [23:0] st[5] = '{24'h0, 24'h400000, 24'h0, 24'hC00000, 24'h400000};
   logic [23:0] ct[5] = '{24'h400000, 24'h0, 24'hC00000, 24'h0, 24'h400000};
   logic [11:0] ft[5] = '{12'h000, 12'h400, 12'h800, 12'hC00, 12'h200};
   logic [23:0] bad[2] = '{24'hF8C000, 24'hE0C000};
   logic [31:0] bst[2] = '{32'h11, 32'h01};
   sei_pkg::sei_fetch_req_type fetch;
   int miscompares = 0, compares = 0;
   always #20 clk_i = ~clk_i;
   sei_interp dut_u
   (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
      .wb_dat_o(dout), .wb_ack_o(ack), .servo_tick_i(tck),
      .counter_dir_i(dir), .fetch_o(fetch), .fetch_data_i(fdat),
      .fetch_ack_i(fack), .pos_o(pos_o), .pos_valid_o(pval)
   );
   sei_fetch_model far_u
   (
      .clk_i(clk_i), .rst_i(rst_i), .fetch_i(fetch), .wait_i(wt),
      .cnt_adr_i(cadr), .adc_adr_i(aadr), .cnt_val_i(cval),
      .sin_val_i(sval), .cos_val_i(cosv), .data_o(fdat), .ack_o(fack),
      .miss_o(miss)
   );
   task final_report;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Entered just after a rising edge; ack and data taken at a rising edge
   task wb(input logic w, input logic [7:0] a, input logic [23:0] d);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {8'h00, d};
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1)
      begin
         miscompares++;
         $display("[FAIL] wb ack expected 1 seen %b", ack);
      end
      rd = dout;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task rdc(input logic [7:0] a, input logic [31:0] m, e, input string n);
      wb(1'b0, a, 24'h0);
      chk(n, e, rd & m);
   endtask : rdc
   task setup(input logic [23:0] l1, l2, l3, input logic [23:0] c);
      wb(1'b1, sei_pkg::OFS_LINE1, l1);
      wb(1'b1, sei_pkg::OFS_LINE2, l2);
      wb(1'b1, sei_pkg::OFS_LINE3, l3);
      wb(1'b1, sei_pkg::OFS_CTRL, c);
   endtask : setup
   task tick;
      int n;
      tck <= 1'b1;
      @(posedge clk_i);
      tck <= 1'b0;
      got = 1'b0;
      n = 0;
      while (!got && n < 80)
      begin
         @(negedge clk_i);
         n++;
         if (pval === 1'b1)
         begin
            got = 1'b1;
            pos = pos_o;
         end
      end
      @(posedge clk_i);
   endtask : tick
   // Arctangent rounding may land a few steps off an exact angle
   task cpos(input logic [11:0] c, input logic [11:0] f);
      logic [11:0] d;
      d = pos[11:0] - f;
      chk("result strobe", 32'h1, {31'h0, got});
      chk("address miss", 32'h0, {31'h0, miss});
      chk("count part", {20'h0, c}, {20'h0, pos[23:12]});
      chk("fraction", 32'h1, {31'h0, d < 12'h005 || d > 12'hFFB});
   endtask : cpos
   task do_reset(input logic d);
      dir <= d;
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : do_reset
   initial
   begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      final_report();
   end
   initial
   begin
      do_reset(1'b0);
      rdc(sei_pkg::OFS_LINE1, 32'hFFFFFFFF, 32'h0, "line1 reset");
      rdc(8'h1C, 32'hFFFFFFFF, 32'h0, "unmapped");
      rdc(sei_pkg::OFS_STAT, 32'h1F, 32'h0, "stat reset");
      tick();
      chk("disabled", 32'h0, {31'h0, got});
      $display("test reset done");
      cadr <= 16'hC000;
      aadr <= 16'hFF00;
      cval <= 24'h000123;
      setup(24'hF0C000, 24'h00FF00, 24'h0, 24'h3);
      rdc(sei_pkg::OFS_CTRL, 32'h3, 32'h3, "ctrl");
      for (int i = 0; i < 5; i++)
      begin
         sval <= st[i];
         cosv <= ct[i];
         tick();
         cpos(12'h123, ft[i]);
      end
      rdc(sei_pkg::OFS_L3X, 32'hFFF000, 32'h123000, "l3x");
      rdc(sei_pkg::OFS_L2X, 32'hFFFFFF, 32'h0, "l2x idle");
      wb(1'b1, sei_pkg::OFS_LINE3, 24'h200400);
      rdc(sei_pkg::OFS_LINE3, 32'hFFFFFF, 32'h200400, "line3");
      sval <= 24'hE00000;
      cosv <= 24'h000000;
      tick();
      cpos(12'h123, 12'h000);
      $display("test three-line done");
      cadr <= 16'hC021;
      aadr <= 16'hC022;
      cval <= 24'hABC456;
      wt <= 4'h3;
      sval <= 24'h400000;
      setup(24'hF0C020, 24'h00C022, 24'h0, 24'h1);
      tick();
      cpos(12'h456, 12'h400);
      rdc(sei_pkg::OFS_L2X, 32'hFFF000, 32'h456000, "l2x");
      cadr <= 16'hC008;
      aadr <= 16'hFFC2;
      wt <= 4'h0;
      setup(24'hF8C008, 24'h00FFC2, 24'h0, 24'h1);
      tick();
      cpos(12'h456, 12'h400);
      chk("address miss", 32'h0, {31'h0, miss});
      $display("test two-line done");
      tck <= 1'b1;
      @(posedge clk_i);
      tck <= 1'b0;
      repeat (4) @(posedge clk_i);
      tick();
      rdc(sei_pkg::OFS_STAT, 32'h2, 32'h2, "overrun");
      wb(1'b1, sei_pkg::OFS_STAT, 24'h2);
      rdc(sei_pkg::OFS_STAT, 32'h2, 32'h0, "overrun clear");
      for (int i = 0; i < 2; i++)
      begin
         setup(bad[i], 24'h00FF00, 24'h0, 24'h3);
         tick();
         chk("no result", 32'h0, {31'h0, got});
         rdc(sei_pkg::OFS_STAT, 32'h11, bst[i], "setup error");
         wb(1'b1, sei_pkg::OFS_STAT, 24'h13);
      end
      $display("test refusal done");
      cadr <= 16'hC000;
      aadr <= 16'hFF00;
      cval <= 24'h000123;
      sval <= 24'h400000;
      cosv <= 24'h0;
      do_reset(1'b1);
      setup(24'hF0C000, 24'h00FF00, 24'h0, 24'h3);
      tick();
      cpos(12'h123, 12'hC00);
      dir <= 1'b0;
      tick();
      cpos(12'h123, 12'hC00);
      rdc(sei_pkg::OFS_STAT, 32'h4, 32'h4, "direction");
      $display("test direction done");
      final_report();
   end
endmodule : sei_interp_tb
